/* rtl/uhcp_pkg.sv */
// Purpose: Shared constants for the serial command port
// Assumes: 100 MHz core clock
// Notes:   Parameter word layout and tunnel codes are local choices
package uhcp_pkg;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned BASE_BPS       = 1200;
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned ADDR_W         = 16;
	localparam int unsigned PER_W          = 17;
	localparam int unsigned HWP_W          = 16;
	// Rate index 0..5 is 1200..38400 bps
	localparam logic [2:0]  RATE_MAX       = 3'h5;
	localparam logic [2:0]  RATE_SLOW_MAX  = 3'h3;
	// Parameter word fields
	localparam int unsigned HWP_RATE_LSB   = 0;
	localparam int unsigned HWP_WAIT_LSB   = 3;
	localparam int unsigned HWP_NOTE_BIT   = 7;
	// Frame codes
	localparam logic [7:0]  SYNC_CODE      = 8'h66;
	localparam logic [7:0]  NOTE_CODE      = 8'hfe;
	localparam logic [7:0]  CMD_READ       = 8'h08;
	localparam logic [7:0]  CMD_WRITE      = 8'h18;
	localparam logic [7:0]  CMD_INQUIRY    = 8'h28;
	localparam logic [7:0]  CMD_ANSWER     = 8'h38;
	localparam logic [7:0]  READ_LEN_MAX   = 8'hfe;
	localparam logic [7:0]  WRITE_LEN_MAX  = 8'hfb;
	localparam logic [8:0]  HDR_BYTES      = 9'h004;
	// Status codes
	localparam logic [7:0]  ST_OK          = 8'h05;
	localparam logic [7:0]  ST_SUM_ERR     = 8'h06;
	localparam logic [7:0]  ST_NO_CMD      = 8'h16;
	localparam logic [7:0]  ST_PARAM_ERR   = 8'h26;
	localparam logic [7:0]  ST_TUNNEL_ERR  = 8'h36;
	localparam logic [7:0]  ST_RO_ERR      = 8'h46;
	localparam logic [7:0]  ST_BUSY        = 8'h07;
	// Timing
	localparam int unsigned IDLE_CHAR_BITS = 33;
	localparam int unsigned IDLE_SLOW_MS   = 10;
	localparam int unsigned IDLE_SLOW_CYC  = IDLE_SLOW_MS * (CLK_HZ / 1000);
	localparam int unsigned NOTE_PULSE_US  = 1280;
	localparam int unsigned NOTE_PULSE_CYC = NOTE_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned WAIT_UNIT_MS   = 1;
	localparam int unsigned WAIT_UNIT_CYC  = WAIT_UNIT_MS * (CLK_HZ / 1000);
	localparam int unsigned MEM_BYTES_DEF  = 8192;
	localparam int unsigned FIFO_DEPTH     = 8;

	// Bit period in clock cycles for a rate index
	function automatic logic [PER_W-1:0] rate_period(input logic [2:0] idx);
		logic [2:0] i;
		i = (idx > RATE_MAX) ? RATE_MAX : idx;
		return PER_W'(CLK_HZ / (BASE_BPS << i));
	endfunction
endpackage

/* rtl/uhcp_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Output data is read from the storage array
`timescale 1ns/10ps
module uhcp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wptr_reg;
	logic [AW-1:0]    rptr_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* rtl/uhcp_tx.sv */
// Purpose: Character transmitter, start, 8 data LSB first, even parity, stop
// Assumes: Bit period held steady during a character
// Notes:   Line idles high
`timescale 1ns/10ps
module uhcp_tx
	import uhcp_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [PER_W-1:0] bit_per,
	input  wire logic             in_valid,
	input  wire logic [7:0]       in_data,
	output logic                  in_ready,
	output logic                  tx_out
);
	logic             busy_reg;
	logic [3:0]       bitn_reg;
	logic [PER_W-1:0] cnt_reg;
	logic [10:0]      sh_reg;

	assign in_ready = ~busy_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
			bitn_reg <= '0;
			cnt_reg  <= '0;
			sh_reg   <= '1;
			tx_out   <= 1'b1;
		end else if (!busy_reg) begin
			tx_out <= 1'b1;
			if (in_valid) begin
				// Stop, parity, data, start
				sh_reg   <= {1'b1, ^in_data, in_data, 1'b0};
				busy_reg <= 1'b1;
				bitn_reg <= '0;
				cnt_reg  <= '0;
			end
		end else begin
			tx_out <= sh_reg[0];
			if (cnt_reg == bit_per - 1'b1) begin
				cnt_reg  <= '0;
				sh_reg   <= {1'b1, sh_reg[10:1]};
				bitn_reg <= bitn_reg + 1'b1;
				if (bitn_reg == 4'ha) begin
					busy_reg <= 1'b0;
				end
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule

/* rtl/uhcp_port.sv */
// Purpose: Serial command port: frame receive, READ/WRITE execution, response
// Assumes: rx_in synchronous to core_clk; memory returns read data one cycle after mem_re
// Notes:   Response bytes pass through an 8-word FIFO to the transmitter
`timescale 1ns/10ps

module uhcp_port
	import uhcp_pkg::*;
#(
	parameter int unsigned IDLE_SLOW_CYCLES = IDLE_SLOW_CYC,
	parameter int unsigned NOTE_CYCLES      = NOTE_PULSE_CYC,
	parameter int unsigned WAIT_UNIT_CYCLES = WAIT_UNIT_CYC,
	parameter int unsigned MEM_BYTES        = MEM_BYTES_DEF,
	parameter int unsigned CLK_FREQ_HZ      = CLK_HZ
) (
	input  wire logic                           core_clk,
	input  wire logic                           rstn,
	input  wire logic                           rx_in,
	output logic                                tx_out,
	output logic                                irq_n_out,
	input  wire logic [uhcp_pkg::HWP_W-1:0]     nonvolatile_hw_parameter,
	input  wire logic [uhcp_pkg::ADDR_W-1:0]    read_only_area_setting,
	input  wire logic                           notify_req,
	output logic      [uhcp_pkg::ADDR_W-1:0]    mem_addr,
	output logic                                mem_we,
	output logic                                mem_re,
	output logic      [uhcp_pkg::BYTE_W-1:0]    mem_wdata,
	input  wire logic [uhcp_pkg::BYTE_W-1:0]    mem_rdata
);
	import uhcp_pkg::*;

	typedef enum logic [1:0] {R_IDLE, R_START, R_BITS} uhcp_rx_e;
	typedef enum logic [3:0] {E_IDLE, E_WAIT, E_WR, E_SYNC, E_STAT,
		E_RREQ, E_RDAT, E_SUM, E_NOTE} uhcp_eng_e;

	// ------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------
	logic [2:0]       rate_idx;
	logic [3:0]       wait_units;
	logic             note_on_tx;
	logic [PER_W-1:0] nom_per;
	logic [23:0]      wait_cyc;
	logic [20:0]      idle_lim;

	// Bit period in clocks for a rate index at this clock
	function automatic logic [PER_W-1:0] bit_period(input logic [2:0] idx);
		logic [2:0] i;
		i = (idx > RATE_MAX) ? RATE_MAX : idx;
		return PER_W'(CLK_FREQ_HZ / (BASE_BPS << i));
	endfunction

	assign rate_idx   = nonvolatile_hw_parameter[HWP_RATE_LSB +: 3];
	assign wait_units = nonvolatile_hw_parameter[HWP_WAIT_LSB +: 4];
	assign note_on_tx = nonvolatile_hw_parameter[HWP_NOTE_BIT];
	assign nom_per    = bit_period(rate_idx);
	assign wait_cyc   = 24'(wait_units * WAIT_UNIT_CYCLES);

	// ------------------------------------------------------------
	// Character receiver
	// ------------------------------------------------------------
	uhcp_rx_e         rx_st_reg;
	logic             rx_d_reg;
	logic [PER_W-1:0] per_reg;
	logic [PER_W-1:0] rcnt_reg;
	logic [3:0]       rbit_reg;
	logic [9:0]       rsh_reg;
	logic             byte_stb_reg;
	logic [7:0]       byte_reg;
	logic             byte_err_reg;
	logic             fall;
	logic [9:0]       rvec;

	assign fall = rx_d_reg & ~rx_in;
	assign rvec = {rx_in, rsh_reg[9:1]};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_d_reg <= 1'b1;
		end else begin
			rx_d_reg <= rx_in;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_st_reg    <= R_IDLE;
			rcnt_reg     <= '0;
			rbit_reg     <= '0;
			rsh_reg      <= '0;
			byte_stb_reg <= 1'b0;
			byte_reg     <= '0;
			byte_err_reg <= 1'b0;
		end else begin
			byte_stb_reg <= 1'b0;
			unique case (rx_st_reg)
				R_IDLE: begin
					rcnt_reg <= '0;
					if (fall) begin
						rx_st_reg <= R_START;
					end
				end
				R_START: begin
					rcnt_reg <= rcnt_reg + 1'b1;
					if (rcnt_reg == (per_reg >> 1)) begin
						rcnt_reg  <= '0;
						rbit_reg  <= '0;
						rx_st_reg <= rx_in ? R_IDLE : R_BITS;
					end
				end
				R_BITS: begin
					rcnt_reg <= rcnt_reg + 1'b1;
					if (rcnt_reg == per_reg - 1'b1) begin
						rcnt_reg <= '0;
						rsh_reg  <= rvec;
						rbit_reg <= rbit_reg + 1'b1;
						if (rbit_reg == 4'h9) begin
							rx_st_reg    <= R_IDLE;
							byte_stb_reg <= 1'b1;
							byte_reg     <= rvec[7:0];
							byte_err_reg <= ~rvec[9] | (rvec[8] != ^rvec[7:0]);
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bit timing calibration
	// ------------------------------------------------------------
	logic        fr_act_reg;
	logic        cal_run_reg;
	logic        cal_fall_reg;
	logic [19:0] cal_cnt_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cal_run_reg  <= 1'b0;
			cal_fall_reg <= 1'b0;
			cal_cnt_reg  <= '0;
			per_reg      <= bit_period(3'h0);
		end else if (!fr_act_reg && rx_st_reg == R_IDLE && fall) begin
			cal_run_reg  <= 1'b1;
			cal_fall_reg <= 1'b0;
			cal_cnt_reg  <= 20'h00001;
			per_reg      <= nom_per;
		end else if (cal_run_reg) begin
			cal_cnt_reg <= cal_cnt_reg + 1'b1;
			if (&cal_cnt_reg) begin
				cal_run_reg <= 1'b0;
			end else if (fall) begin
				cal_fall_reg <= 1'b1;
				if (cal_fall_reg) begin
					cal_run_reg <= 1'b0;
					per_reg     <= cal_cnt_reg[19:3];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Frame assembly
	// ------------------------------------------------------------
	logic [7:0]  buf_mem [256];
	logic [8:0]  idx_reg;
	logic [7:0]  cmd_reg;
	logic [15:0] addr_reg;
	logic [7:0]  len_reg;
	logic [7:0]  sum_reg;
	logic        err_reg;
	logic        end_reg;
	logic [20:0] idle_reg;
	logic [8:0]  size;
	logic        sized;
	logic        is_last;
	logic        idle_out;

	assign idle_lim = (rate_idx > RATE_SLOW_MAX) ? 21'(IDLE_CHAR_BITS * per_reg)
		: 21'(IDLE_SLOW_CYCLES);
	assign sized    = (cmd_reg == CMD_READ) || (cmd_reg == CMD_WRITE);
	assign size     = (cmd_reg == CMD_WRITE) ? HDR_BYTES + 9'(len_reg) : HDR_BYTES;
	assign is_last  = sized && idx_reg >= HDR_BYTES && idx_reg == size;
	assign idle_out = fr_act_reg && idle_reg >= idle_lim;

	always_ff @(posedge core_clk) begin
		if (byte_stb_reg && fr_act_reg && cmd_reg == CMD_WRITE &&
			idx_reg >= HDR_BYTES && idx_reg < size) begin
			buf_mem[8'(idx_reg - HDR_BYTES)] <= byte_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fr_act_reg <= 1'b0;
			idx_reg    <= '0;
			cmd_reg    <= '0;
			addr_reg   <= '0;
			len_reg    <= '0;
			sum_reg    <= '0;
			err_reg    <= 1'b0;
			end_reg    <= 1'b0;
			idle_reg   <= '0;
		end else begin
			end_reg  <= 1'b0;
			idle_reg <= (rx_st_reg == R_IDLE && fr_act_reg) ? idle_reg + 1'b1 : '0;
			if (!fr_act_reg) begin
				if (byte_stb_reg && !byte_err_reg && byte_reg == SYNC_CODE) begin
					fr_act_reg <= 1'b1;
					idx_reg    <= '0;
					cmd_reg    <= '0;
					len_reg    <= '0;
					sum_reg    <= '0;
					err_reg    <= 1'b0;
				end
			end else if (byte_stb_reg) begin
				sum_reg <= sum_reg + byte_reg;
				err_reg <= err_reg | byte_err_reg;
				if (idx_reg != '1) begin
					idx_reg <= idx_reg + 1'b1;
				end
				unique case (idx_reg)
					9'h000: cmd_reg <= byte_reg;
					9'h001: addr_reg[15:8] <= byte_reg;
					9'h002: addr_reg[7:0] <= byte_reg;
					9'h003: len_reg <= byte_reg;
					default: ;
				endcase
				if (is_last) begin
					fr_act_reg <= 1'b0;
					end_reg    <= 1'b1;
				end
			end else if (idle_out) begin
				fr_act_reg <= 1'b0;
				end_reg    <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Status decision
	// ------------------------------------------------------------
	logic [7:0]  st_new;
	logic [16:0] span;

	assign span = 17'(addr_reg) + 17'(len_reg);

	always_comb begin
		st_new = ST_OK;
		if (err_reg || sum_reg != '0) begin
			st_new = ST_SUM_ERR;
		end else if (cmd_reg == CMD_INQUIRY || cmd_reg == CMD_ANSWER) begin
			st_new = ST_TUNNEL_ERR;
		end else if (cmd_reg == CMD_READ) begin
			if (idx_reg != HDR_BYTES + 9'h001 || len_reg == '0 || len_reg > READ_LEN_MAX ||
				span > 17'(MEM_BYTES)) begin
				st_new = ST_PARAM_ERR;
			end
		end else if (cmd_reg == CMD_WRITE) begin
			if (idx_reg != size + 9'h001 || len_reg == '0 || len_reg > WRITE_LEN_MAX ||
				span > 17'(MEM_BYTES)) begin
				st_new = ST_PARAM_ERR;
			end else if (addr_reg < read_only_area_setting) begin
				st_new = ST_RO_ERR;
			end
		end else begin
			st_new = ST_NO_CMD;
		end
	end

	// ------------------------------------------------------------
	// Execution and response
	// ------------------------------------------------------------
	uhcp_eng_e   eng_reg;
	logic [7:0]  st_reg;
	logic        x_rd_reg;
	logic        x_wr_reg;
	logic [15:0] x_addr_reg;
	logic [7:0]  x_len_reg;
	logic [7:0]  ptr_reg;
	logic [7:0]  tsum_reg;
	logic [23:0] wcnt_reg;
	logic        busy_pend_reg;
	logic        note_pend_reg;
	logic [17:0] irq_cnt_reg;
	logic        push_valid;
	logic [7:0]  push_data;
	logic        push_ready;
	logic        f_valid;
	logic [7:0]  f_data;
	logic        f_ready;
	logic        last_byte;

	assign last_byte = (ptr_reg == x_len_reg - 1'b1);
	assign mem_addr  = x_addr_reg + 16'(ptr_reg);
	assign mem_wdata = buf_mem[ptr_reg];
	assign mem_we    = (eng_reg == E_WR);
	assign mem_re    = (eng_reg == E_RREQ);

	always_comb begin
		push_valid = 1'b1;
		unique case (eng_reg)
			E_SYNC:  push_data = SYNC_CODE;
			E_STAT:  push_data = st_reg;
			E_RDAT:  push_data = mem_rdata;
			E_SUM:   push_data = 8'(-tsum_reg);
			E_NOTE:  push_data = NOTE_CODE;
			default: begin
				push_valid = 1'b0;
				push_data  = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_pend_reg <= 1'b0;
		end else if (end_reg && eng_reg != E_IDLE) begin
			busy_pend_reg <= 1'b1;
		end else if (eng_reg == E_IDLE) begin
			busy_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			note_pend_reg <= 1'b0;
		end else if (notify_req) begin
			note_pend_reg <= 1'b1;
		end else if (eng_reg == E_IDLE && !end_reg && !busy_pend_reg) begin
			note_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_cnt_reg <= '0;
			irq_n_out   <= 1'b1;
		end else if (note_pend_reg && eng_reg == E_IDLE && !end_reg && !busy_pend_reg) begin
			irq_cnt_reg <= 18'(NOTE_CYCLES - 1);
			irq_n_out   <= 1'b0;
		end else if (irq_cnt_reg != '0) begin
			irq_cnt_reg <= irq_cnt_reg - 1'b1;
		end else begin
			irq_n_out <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			eng_reg    <= E_IDLE;
			st_reg     <= ST_OK;
			x_rd_reg   <= 1'b0;
			x_wr_reg   <= 1'b0;
			x_addr_reg <= '0;
			x_len_reg  <= '0;
			ptr_reg    <= '0;
			tsum_reg   <= '0;
			wcnt_reg   <= '0;
		end else begin
			unique case (eng_reg)
				E_IDLE: begin
					ptr_reg  <= '0;
					wcnt_reg <= '0;
					if (end_reg) begin
						st_reg     <= st_new;
						x_rd_reg   <= (cmd_reg == CMD_READ);
						x_wr_reg   <= (cmd_reg == CMD_WRITE);
						x_addr_reg <= addr_reg;
						x_len_reg  <= len_reg;
						eng_reg    <= E_WAIT;
					end else if (busy_pend_reg) begin
						st_reg   <= ST_BUSY;
						x_rd_reg <= 1'b0;
						eng_reg  <= E_SYNC;
					end else if (note_pend_reg && note_on_tx) begin
						eng_reg <= E_NOTE;
					end
				end
				E_WAIT: begin
					wcnt_reg <= wcnt_reg + 1'b1;
					if (wcnt_reg >= wait_cyc) begin
						eng_reg <= (x_wr_reg && st_reg == ST_OK) ? E_WR : E_SYNC;
					end
				end
				E_WR: begin
					ptr_reg <= ptr_reg + 1'b1;
					if (last_byte) begin
						ptr_reg <= '0;
						eng_reg <= E_SYNC;
					end
				end
				E_SYNC: begin
					if (push_ready) begin
						eng_reg <= E_STAT;
					end
				end
				E_STAT: begin
					if (push_ready) begin
						tsum_reg <= st_reg;
						eng_reg  <= (x_rd_reg && st_reg == ST_OK) ? E_RREQ : E_SUM;
					end
				end
				E_RREQ: begin
					eng_reg <= E_RDAT;
				end
				E_RDAT: begin
					if (push_ready) begin
						tsum_reg <= tsum_reg + mem_rdata;
						ptr_reg  <= ptr_reg + 1'b1;
						eng_reg  <= last_byte ? E_SUM : E_RREQ;
					end
				end
				E_SUM: begin
					if (push_ready) begin
						eng_reg <= E_IDLE;
					end
				end
				E_NOTE: begin
					if (push_ready) begin
						eng_reg <= E_IDLE;
					end
				end
				default: eng_reg <= E_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	uhcp_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_valid  (push_valid),
		.in_data   (push_data),
		.in_ready  (push_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_ready)
	);

	uhcp_tx u_tx (
		.core_clk (core_clk),
		.rstn     (rstn),
		.bit_per  (nom_per),
		.in_valid (f_valid),
		.in_data  (f_data),
		.in_ready (f_ready),
		.tx_out   (tx_out)
	);
endmodule

/* tb/uhcp_port_monitor.sv */
// Purpose: Port checks for the serial command port
// Assumes: Rate index 5, so one bit is BIT_PER clocks
// Notes:   Bound to uhcp_port below
`timescale 1ns/10ps
module uhcp_port_monitor
	import uhcp_pkg::*;
#(
	parameter int unsigned NOTE_CYCLES = 200,
	parameter int unsigned MEM_BYTES   = 8192,
	parameter int unsigned BIT_PER     = 2604
) (
	input wire logic                        core_clk,
	input wire logic                        rstn,
	input wire logic                        rx_in,
	input wire logic                        tx_out,
	input wire logic                        irq_n_out,
	input wire logic [uhcp_pkg::ADDR_W-1:0] read_only_area_setting,
	input wire logic [uhcp_pkg::ADDR_W-1:0] mem_addr,
	input wire logic                        mem_we,
	input wire logic                        mem_re
);
	logic [31:0] lo_cnt_reg;
	logic [31:0] irq_cnt_reg;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// Length of the current low run on tx
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			lo_cnt_reg <= '0;
		else
			lo_cnt_reg <= tx_out ? '0 : lo_cnt_reg + 32'h1;
	end
	// Length of the current low run on irq
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			irq_cnt_reg <= '0;
		else
			irq_cnt_reg <= irq_n_out ? '0 : irq_cnt_reg + 32'h1;
	end
	property p_rx_quiet; !rx_in |-> tx_out; endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("tx active while host sends");
	property p_rx_no_exec; !rx_in |-> !(mem_we || mem_re); endproperty
	a_rx_no_exec: assert property (p_rx_no_exec) else $error("memory access during reception");
	property p_rw_excl; !(mem_we && mem_re); endproperty
	a_rw_excl: assert property (p_rw_excl) else $error("read and write strobes together");
	property p_ro_area; mem_we |-> mem_addr >= read_only_area_setting; endproperty
	a_ro_area: assert property (p_ro_area) else $error("write into read-only area");
	property p_mem_range; (mem_we || mem_re) |-> mem_addr < MEM_BYTES; endproperty
	a_mem_range: assert property (p_mem_range) else $error("access beyond memory");
	property p_we_step; mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 16'h1; endproperty
	a_we_step: assert property (p_we_step) else $error("write address not incrementing");
	property p_bit_len; $rose(tx_out) |-> (lo_cnt_reg % BIT_PER) == 0; endproperty
	a_bit_len: assert property (p_bit_len) else $error("tx low run not whole bits");
	property p_irq_len; $rose(irq_n_out) |-> irq_cnt_reg == NOTE_CYCLES; endproperty
	a_irq_len: assert property (p_irq_len) else $error("irq pulse length wrong");
endmodule
bind uhcp_port uhcp_port_monitor #(.NOTE_CYCLES(NOTE_CYCLES), .MEM_BYTES(MEM_BYTES),
	.BIT_PER(CLK_FREQ_HZ / (BASE_BPS << RATE_MAX))) u_mon (.*);

/* tb/uhcp_host_model.sv */
// Purpose: Host side of the serial link
// Assumes: Same rate as the port, index 5
// Notes:   No handshake lines; waits for each full response
`timescale 1ns/10ps
module uhcp_host_model #(
	parameter int BIT_PER = 2604
) (
	input  wire logic core_clk,
	output logic      rx_in,
	input  wire logic tx_out
);
	localparam logic [7:0] SYNC_BYTE = 8'h66;
	initial rx_in = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [10:0] c;
		c = {1'b1, ^b, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_in <= c[i];
			repeat (BIT_PER) @(posedge core_clk);
		end
	endtask
	task automatic frame(input logic [7:0] d[$], input logic [7:0] bias);
		logic [7:0] s;
		s = bias;
		send(SYNC_BYTE);
		foreach (d[i]) begin
			send(d[i]);
			s = s - d[i];
		end
		send(s);
	endtask
	task automatic recv(output logic [7:0] b, output logic ok);
		logic [10:0] c;
		int n;
		n = 0;
		while (tx_out !== 1'b0 && n < 80 * BIT_PER) begin
			@(posedge core_clk);
			n++;
		end
		repeat (BIT_PER / 2) @(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			if (i > 0)
				repeat (BIT_PER) @(posedge core_clk);
			c[i] = tx_out;
		end
		b = c[8:1];
		ok = (c[0] === 1'b0) && (c[10] === 1'b1) && (c[9] === ^c[8:1]);
	endtask
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the serial command port
// Assumes: Rate index 5, wait field 1, read-only below 0x0020
// Notes:   Byte memory model answers one cycle after mem_re
`timescale 1ns/10ps
module tb;
	import uhcp_pkg::*;
	logic        core_clk, rstn, rx_in, tx_out, irq_n_out, notify_req, mem_we, mem_re;
	logic [15:0] nonvolatile_hw_parameter, read_only_area_setting, mem_addr;
	logic [7:0]  mem_wdata, mem_rdata;
	logic [7:0]  mem[256];
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	localparam int BIT_PER = 32;
	uhcp_port #(.IDLE_SLOW_CYCLES(2000), .NOTE_CYCLES(200), .WAIT_UNIT_CYCLES(50),
		.CLK_FREQ_HZ(BIT_PER * (BASE_BPS << RATE_MAX))) u_dut (.*);
	uhcp_host_model #(.BIT_PER(BIT_PER)) u_host (.*);
	always @(posedge core_clk) begin
		if (mem_we)
			mem[mem_addr[7:0]] <= mem_wdata;
		if (mem_re)
			mem_rdata <= mem[mem_addr[7:0]];
		cyc++;
		if (cyc == 80_000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic resp(input logic [7:0] e[$]);
		logic [7:0] b, s;
		logic ok;
		s = 8'h00;
		foreach (e[i]) begin
			u_host.recv(b, ok);
			chk("response byte", e[i], b);
			chk("character framing", 1'b1, ok);
			if (i > 0)
				s = s - e[i];
		end
		u_host.recv(b, ok);
		chk("checksum", s, b);
		chk("checksum framing", 1'b1, ok);
		repeat (BIT_PER) @(posedge core_clk);
	endtask
	task automatic t_irq();
		logic [15:0] n;
		n = 0;
		notify_req <= 1'b1;
		@(posedge core_clk);
		notify_req <= 1'b0;
		while (irq_n_out !== 1'b0 && n < 999) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (irq_n_out === 1'b0 && n < 999) begin
			@(negedge core_clk);
			n++;
		end
		chk("irq low cycles", 16'h00c8, n);
		@(posedge core_clk);
		$display("irq test done");
	endtask
	task automatic t_note();
		logic [7:0] b;
		logic       ok;
		nonvolatile_hw_parameter <= 16'h008d;
		notify_req <= 1'b1;
		@(posedge core_clk);
		notify_req <= 1'b0;
		u_host.recv(b, ok);
		chk("notify code", NOTE_CODE, b);
		chk("notify framing", 1'b1, ok);
		u_host.recv(b, ok);
		chk("notify trailer", 1'b0, ok);
		nonvolatile_hw_parameter <= 16'h000d;
		$display("notify test done");
	endtask
	task automatic t_rw();
		u_host.frame('{CMD_READ, 8'h00, 8'h10, 8'h02}, 8'h00);
		resp('{SYNC_CODE, ST_OK, 8'h4a, 8'h4b});
		u_host.frame('{CMD_WRITE, 8'h00, 8'h40, 8'h02, 8'ha1, 8'hb2}, 8'h00);
		resp('{SYNC_CODE, ST_OK});
		u_host.frame('{CMD_READ, 8'h00, 8'h40, 8'h02}, 8'h00);
		resp('{SYNC_CODE, ST_OK, 8'ha1, 8'hb2});
		$display("read write test done");
	endtask
	task automatic t_err();
		u_host.frame('{CMD_WRITE, 8'h00, 8'h10, 8'h01, 8'hc3}, 8'h00);
		resp('{SYNC_CODE, ST_RO_ERR});
		u_host.frame('{CMD_READ, 8'h00, 8'h10, 8'h01}, 8'h01);
		resp('{SYNC_CODE, ST_SUM_ERR});
		u_host.frame('{CMD_READ, 8'h00, 8'h10, 8'hff}, 8'h00);
		resp('{SYNC_CODE, ST_PARAM_ERR});
		u_host.frame('{8'h48, 8'h00, 8'h10, 8'h01}, 8'h00);
		resp('{SYNC_CODE, ST_NO_CMD});
		u_host.frame('{CMD_INQUIRY}, 8'h00);
		resp('{SYNC_CODE, ST_TUNNEL_ERR});
		$display("error test done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		rstn = 1'b0;
		notify_req = 1'b0;
		mem_rdata = 8'h00;
		nonvolatile_hw_parameter = 16'h000d;
		read_only_area_setting = 16'h0020;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_irq();
		t_note();
		t_rw();
		t_err();
		wrap_up();
	end
endmodule
